// ===== mmn_exec.sv
`timescale 1ns/1ns
// What this block does
// - Double float copied raw into register pair.
// - Pair is named register and next one.
// - Register pair copied raw into double float.
// - Selector 0 reads PSW, 1 SSW.
// - Same selectors on write; PSW write sets codes.
// - User-mode SSW write does nothing.
// - Single float move copies unchanged, no trap.
// - Supervisor-to-user move sets N Z, clears C.
// - User-to-supervisor move sets N Z, clears V.
// - Single float and word moves are raw.
// - Word move sets N, Z, clears V.
// - Double multiply with four flags and traps.
// - Single multiply with four flags and traps.
// - Multiply trap keeps PC and old destination.
// - Signed multiply low word, overflow, clear N Z C.
// - Unsigned multiply low word, overflow flag.
// - Unsigned extended multiply writes 64-bit pair.
// - Signed extended multiply writes 64-bit pair.
// - Double negate flips sign bit only.
// - Single negate flips sign bit only.
// - Status retrieval returns saved PC and value.

// ****************************************************************
// Single-cycle execute stage: operands are presented with i_valid,
// results appear registered one clock later with o_done.
// ****************************************************************
module mmn_exec #(
  parameter int W = 32                          // General word width.
) (
  input  wire logic                i_ref_clk,   // Processor clock.
  input  wire logic                i_reset,     // Asynchronous reset.
  input  wire logic                i_valid,     // Operation request.
  input  wire mmn_pkg::mmn_op_t    i_op,        // Decoded operation.
  input  wire logic [15:0]         i_instr,     // Raw instruction word.
  input  wire logic [W-1:0]        i_pc,        // PC of the instruction.
  input  wire logic                i_user_mode, // High in user mode.
  input  wire logic [W-1:0]        i_gpr_a,     // Source general reg.
  input  wire logic [W-1:0]        i_gpr_b,     // Dest reg or next.
  input  wire logic [2*W-1:0]      i_fpr_a,     // Source float reg.
  input  wire logic [2*W-1:0]      i_fpr_b,     // Dest float reg.
  input  wire logic [2*W-1:0]      i_fmul_res,  // External FP product.
  input  wire logic [3:0]          i_fmul_exc,  // X,U,V,I from FP unit.
  input  wire logic [3:0]          i_fexc_en,   // Trap enables X,U,V,I.
  output logic                     o_done,      // Result valid pulse.
  output logic                     o_gpr_we,    // Write dest gpr.
  output logic                     o_gpr_we_hi, // Also write dest+1.
  output logic                     o_gpr_usr,   // Dest in user bank.
  output logic [3:0]               o_gpr_dst,   // Dest gpr number.
  output logic [2*W-1:0]           o_gpr_data,  // Low word then high.
  output logic                     o_fpr_we,    // Write dest fpr.
  output logic                     o_fpr_dbl,   // 64-bit fpr write.
  output logic [3:0]               o_fpr_dst,   // Dest fpr number.
  output logic [2*W-1:0]           o_fpr_data,  // Float result.
  output logic                     o_cc_we,     // Condition codes updated.
  output logic                     o_trap_priv, // Privileged trap pulse.
  output logic                     o_trap_fp,   // Float trap pulse.
  output logic [W-1:0]             o_psw,       // Program status word.
  output logic [W-1:0]             o_ssw,       // Supervisor status word.
  output logic                     o_float_inexact_flag,   // Sticky.
  output logic                     o_float_underflow_flag, // Sticky.
  output logic                     o_float_overflow_flag,  // Sticky.
  output logic                     o_float_invalid_flag    // Sticky.
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Builds N and Z from a word; the caller decides V and C.
  function automatic logic [1:0] nz_of(input logic [W-1:0] v);
    nz_of = {v[W-1], (v == '0)};
  endfunction

  // Result state; each output register has a _nxt twin.
  logic                done_r,  done_nxt;
  logic                gwe_r,   gwe_nxt;
  logic                ghi_r,   ghi_nxt;
  logic                gusr_r,  gusr_nxt;
  logic [3:0]          gdst_r,  gdst_nxt;
  logic [2*W-1:0]      gdat_r,  gdat_nxt;
  logic                fwe_r,   fwe_nxt;
  logic                fdbl_r,  fdbl_nxt;
  logic [3:0]          fdst_r,  fdst_nxt;
  logic [2*W-1:0]      fdat_r,  fdat_nxt;
  logic                ccwe_r,  ccwe_nxt;
  logic                tpr_r,   tpr_nxt;
  logic                tfp_r,   tfp_nxt;
  logic [W-1:0]        psw_r,   psw_nxt;
  logic [W-1:0]        ssw_r,   ssw_nxt;
  logic [3:0]          fflg_r,  fflg_nxt;   // Sticky I,V,U,X flags.
  logic [W-1:0]        fpc_r,   fpc_nxt;    // Saved faulting PC.
  logic [2*W-1:0]      fold_r,  fold_nxt;   // Saved old destination.

  // Operand fields and products.
  logic [3:0]          dst;
  logic [3:0]          psel;
  logic signed [2*W-1:0] sprod;
  logic [2*W-1:0]      uprod;
  logic [3:0]          fhit;

  assign dst   = i_instr[mmn_pkg::MMN_DST_HI:mmn_pkg::MMN_DST_LO];
  assign psel  = i_instr[mmn_pkg::MMN_SRC_HI:mmn_pkg::MMN_SRC_LO];
  assign sprod = $signed(i_gpr_b) * $signed(i_gpr_a);
  assign uprod = i_gpr_b * i_gpr_a;
  assign fhit  = i_fmul_exc & i_fexc_en;

  // ****************************************************************
  // Next-state logic for every operation.
  // ****************************************************************
  always_comb begin
    logic [1:0] nz;
    nz       = 2'b00;
    done_nxt = i_valid;
    gwe_nxt  = 1'b0;
    ghi_nxt  = 1'b0;
    gusr_nxt = 1'b0;
    gdst_nxt = dst;
    gdat_nxt = '0;
    fwe_nxt  = 1'b0;
    fdbl_nxt = 1'b0;
    fdst_nxt = dst;
    fdat_nxt = '0;
    ccwe_nxt = 1'b0;
    tpr_nxt  = 1'b0;
    tfp_nxt  = 1'b0;
    psw_nxt  = psw_r;
    ssw_nxt  = ssw_r;
    fflg_nxt = fflg_r;
    fpc_nxt  = fpc_r;
    fold_nxt = fold_r;
    if (i_valid) begin
      unique case (i_op)
        mmn_pkg::MMN_OP_MOVW: begin
          gwe_nxt  = 1'b1;
          gdat_nxt = {{W{1'b0}}, i_gpr_a};
          nz       = nz_of(i_gpr_a);
          ccwe_nxt = 1'b1;
          psw_nxt[mmn_pkg::MMN_CC_N] = nz[1];
          psw_nxt[mmn_pkg::MMN_CC_Z] = nz[0];
          psw_nxt[mmn_pkg::MMN_CC_V] = 1'b0;
        end
        mmn_pkg::MMN_OP_MOVS: begin
          fwe_nxt  = 1'b1;
          fdat_nxt = {{W{1'b0}}, i_fpr_a[W-1:0]};
        end
        mmn_pkg::MMN_OP_MOVD: begin
          fwe_nxt  = 1'b1;
          fdbl_nxt = 1'b1;
          fdat_nxt = i_fpr_a;
        end
        mmn_pkg::MMN_OP_MOVDL: begin
          // Low word to the named register, high word to the next.
          gwe_nxt  = 1'b1;
          ghi_nxt  = 1'b1;
          gdat_nxt = i_fpr_a;
        end
        mmn_pkg::MMN_OP_MOVLD: begin
          // The decoder supplies the pair as gpr_a low, gpr_b high.
          fwe_nxt  = 1'b1;
          fdbl_nxt = 1'b1;
          fdat_nxt = {i_gpr_b, i_gpr_a};
        end
        mmn_pkg::MMN_OP_MOVSW: begin
          gwe_nxt  = 1'b1;
          gdat_nxt = {{W{1'b0}}, i_fpr_a[W-1:0]};
        end
        mmn_pkg::MMN_OP_MOVWS: begin
          fwe_nxt  = 1'b1;
          fdat_nxt = {{W{1'b0}}, i_gpr_a};
        end
        mmn_pkg::MMN_OP_MOVPW: begin
          // Reserved selectors still write, but the value is zero.
          gwe_nxt = 1'b1;
          if (psel == mmn_pkg::MMN_PSEL_PSW) begin
            gdat_nxt = {{W{1'b0}}, psw_r};
          end else if (psel == mmn_pkg::MMN_PSEL_SSW) begin
            gdat_nxt = {{W{1'b0}}, ssw_r};
          end else begin
            gdat_nxt = '0;
          end
        end
        mmn_pkg::MMN_OP_MOVWP: begin
          if (psel == mmn_pkg::MMN_PSEL_PSW) begin
            psw_nxt  = i_gpr_a;
            ccwe_nxt = 1'b1;
          end else if (psel == mmn_pkg::MMN_PSEL_SSW && !i_user_mode) begin
            ssw_nxt = i_gpr_a;
          end
        end
        mmn_pkg::MMN_OP_MOVSU, mmn_pkg::MMN_OP_MOVUS: begin
          if (i_user_mode) begin
            tpr_nxt = 1'b1;
          end else begin
            gwe_nxt  = 1'b1;
            gusr_nxt = (i_op == mmn_pkg::MMN_OP_MOVSU);
            gdat_nxt = {{W{1'b0}}, i_gpr_a};
            nz       = nz_of(i_gpr_a);
            ccwe_nxt = 1'b1;
            psw_nxt[mmn_pkg::MMN_CC_N] = nz[1];
            psw_nxt[mmn_pkg::MMN_CC_Z] = nz[0];
            if (i_op == mmn_pkg::MMN_OP_MOVSU) begin
              psw_nxt[mmn_pkg::MMN_CC_C] = 1'b0;
            end else begin
              psw_nxt[mmn_pkg::MMN_CC_V] = 1'b0;
            end
          end
        end
        mmn_pkg::MMN_OP_MULW, mmn_pkg::MMN_OP_MULWU,
        mmn_pkg::MMN_OP_MULWX, mmn_pkg::MMN_OP_MULWUX: begin
          gwe_nxt  = 1'b1;
          ccwe_nxt = 1'b1;
          psw_nxt[mmn_pkg::MMN_CC_N] = 1'b0;
          psw_nxt[mmn_pkg::MMN_CC_Z] = 1'b0;
          psw_nxt[mmn_pkg::MMN_CC_C] = 1'b0;
          if (i_op == mmn_pkg::MMN_OP_MULW || i_op == mmn_pkg::MMN_OP_MULWX) begin
            // Signed fit test: upper half must equal the sign extension.
            psw_nxt[mmn_pkg::MMN_CC_V] = (sprod[2*W-1:W] != {W{sprod[W-1]}});
            gdat_nxt = sprod;
          end else begin
            psw_nxt[mmn_pkg::MMN_CC_V] = (uprod[2*W-1:W] != '0);
            gdat_nxt = uprod;
          end
          if (i_op == mmn_pkg::MMN_OP_MULWX || i_op == mmn_pkg::MMN_OP_MULWUX) begin
            ghi_nxt = 1'b1;
          end else begin
            gdat_nxt[2*W-1:W] = '0;
          end
        end
        mmn_pkg::MMN_OP_MULS, mmn_pkg::MMN_OP_MULD: begin
          // Flags are sticky; enabled ones trap and keep the context.
          fflg_nxt = fflg_r | i_fmul_exc;
          if (fhit != 4'h0) begin
            tfp_nxt  = 1'b1;
            fpc_nxt  = i_pc;
            fold_nxt = i_fpr_b;
          end else begin
            fwe_nxt  = 1'b1;
            fdbl_nxt = (i_op == mmn_pkg::MMN_OP_MULD);
            fdat_nxt = fdbl_nxt ? i_fmul_res : {{W{1'b0}}, i_fmul_res[W-1:0]};
          end
        end
        mmn_pkg::MMN_OP_NEGS: begin
          fwe_nxt  = 1'b1;
          fdat_nxt = {{W{1'b0}}, i_fpr_a[W-1:0]};
          fdat_nxt[mmn_pkg::MMN_SGN_S] = ~i_fpr_a[mmn_pkg::MMN_SGN_S];
        end
        mmn_pkg::MMN_OP_NEGD: begin
          fwe_nxt  = 1'b1;
          fdbl_nxt = 1'b1;
          fdat_nxt = i_fpr_a;
          fdat_nxt[mmn_pkg::MMN_SGN_D] = ~i_fpr_a[mmn_pkg::MMN_SGN_D];
        end
        mmn_pkg::MMN_OP_LOADFS: begin
          gwe_nxt  = 1'b1;
          gdat_nxt = {{W{1'b0}}, fpc_r};
          fwe_nxt  = 1'b1;
          fdbl_nxt = 1'b1;
          fdst_nxt = dst;
          gdst_nxt = psel;
          fdat_nxt = fold_r;
        end
        default: begin
          done_nxt = i_valid;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      done_r <= 1'b0;
      gwe_r  <= 1'b0;
      ghi_r  <= 1'b0;
      gusr_r <= 1'b0;
      gdst_r <= 4'h0;
      gdat_r <= '0;
      fwe_r  <= 1'b0;
      fdbl_r <= 1'b0;
      fdst_r <= 4'h0;
      fdat_r <= '0;
      ccwe_r <= 1'b0;
      tpr_r  <= 1'b0;
      tfp_r  <= 1'b0;
      psw_r  <= mmn_pkg::MMN_PSW_RST;
      ssw_r  <= mmn_pkg::MMN_SSW_RST;
      fflg_r <= 4'h0;
      fpc_r  <= '0;
      fold_r <= '0;
    end else begin
      done_r <= done_nxt;
      gwe_r  <= gwe_nxt;
      ghi_r  <= ghi_nxt;
      gusr_r <= gusr_nxt;
      gdst_r <= gdst_nxt;
      gdat_r <= gdat_nxt;
      fwe_r  <= fwe_nxt;
      fdbl_r <= fdbl_nxt;
      fdst_r <= fdst_nxt;
      fdat_r <= fdat_nxt;
      ccwe_r <= ccwe_nxt;
      tpr_r  <= tpr_nxt;
      tfp_r  <= tfp_nxt;
      psw_r  <= psw_nxt;
      ssw_r  <= ssw_nxt;
      fflg_r <= fflg_nxt;
      fpc_r  <= fpc_nxt;
      fold_r <= fold_nxt;
    end
  end

  // Outputs come straight from the registers.
  assign o_done      = done_r;
  assign o_gpr_we    = gwe_r;
  assign o_gpr_we_hi = ghi_r;
  assign o_gpr_usr   = gusr_r;
  assign o_gpr_dst   = gdst_r;
  assign o_gpr_data  = gdat_r;
  assign o_fpr_we    = fwe_r;
  assign o_fpr_dbl   = fdbl_r;
  assign o_fpr_dst   = fdst_r;
  assign o_fpr_data  = fdat_r;
  assign o_cc_we     = ccwe_r;
  assign o_trap_priv = tpr_r;
  assign o_trap_fp   = tfp_r;
  assign o_psw       = psw_r;
  assign o_ssw       = ssw_r;
  assign o_float_inexact_flag   = fflg_r[0];
  assign o_float_underflow_flag = fflg_r[1];
  assign o_float_overflow_flag  = fflg_r[2];
  assign o_float_invalid_flag   = fflg_r[3];

endmodule // mmn_exec

// ===== mmn_exec_chk.sv
`timescale 1ns/1ns
// ****************************************************************
// Port-level checker for the execute stage.
// ****************************************************************
module mmn_exec_chk #(
  parameter int W = 32
) (
  input wire logic             i_ref_clk,
  input wire logic             i_reset,
  input wire logic             i_valid,
  input wire mmn_pkg::mmn_op_t i_op,
  input wire logic [15:0]      i_instr,
  input wire logic             i_user_mode,
  input wire logic [2*W-1:0]   i_fpr_a,
  input wire logic [3:0]       i_fmul_exc,
  input wire logic [3:0]       i_fexc_en,
  input wire logic             o_done,
  input wire logic             o_gpr_we,
  input wire logic             o_gpr_we_hi,
  input wire logic [2*W-1:0]   o_gpr_data,
  input wire logic             o_fpr_we,
  input wire logic [2*W-1:0]   o_fpr_data,
  input wire logic             o_cc_we,
  input wire logic [W-1:0]     o_psw,
  input wire logic [W-1:0]     o_ssw,
  input wire logic             o_trap_priv,
  input wire logic             o_trap_fp,
  input wire logic             o_float_inexact_flag
);
  // One clock domain, so clocking and reset are stated once.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  done_one_cycle_a: assert property (i_valid |=> o_done)
    else $error("done missing one cycle after a request");
  no_stray_done_a: assert property (!i_valid |=> !o_done)
    else $error("done seen without a request");
  movdl_pair_a: assert property (i_valid && i_op == mmn_pkg::MMN_OP_MOVDL |=>
    o_gpr_we && o_gpr_we_hi && o_gpr_data == $past(i_fpr_a)) else $error("pair move not raw");
  negs_sign_a: assert property (i_valid && i_op == mmn_pkg::MMN_OP_NEGS |=>
    o_fpr_we && !o_trap_fp && o_fpr_data[31:0] == ($past(i_fpr_a[31:0]) ^ 32'h8000_0000))
    else $error("single negate wrong");
  negd_sign_a: assert property (i_valid && i_op == mmn_pkg::MMN_OP_NEGD |=>
    o_fpr_data == ($past(i_fpr_a) ^ 64'h8000_0000_0000_0000)) else $error("double negate wrong");
  mul_codes_a: assert property (i_valid && (i_op == mmn_pkg::MMN_OP_MULW || i_op == mmn_pkg::MMN_OP_MULWU)
    |=> o_cc_we && o_psw[3:2] == 2'b00 && !o_psw[0]) else $error("multiply codes not cleared");
  priv_trap_a: assert property (i_valid && i_user_mode && (i_op == mmn_pkg::MMN_OP_MOVSU ||
    i_op == mmn_pkg::MMN_OP_MOVUS) |=> o_trap_priv && !o_gpr_we) else $error("bank move not trapped");
  ssw_user_a: assert property (i_valid && i_user_mode && i_op == mmn_pkg::MMN_OP_MOVWP &&
    i_instr[7:4] == 4'h1 |=> $stable(o_ssw) && !o_trap_priv) else $error("user wrote ssw");
  fp_trap_a: assert property (i_valid && (i_op == mmn_pkg::MMN_OP_MULD || i_op == mmn_pkg::MMN_OP_MULS) &&
    |(i_fmul_exc & i_fexc_en) |=> o_trap_fp && !o_fpr_we) else $error("float trap missing");
  rsv_read_a: assert property (i_valid && i_op == mmn_pkg::MMN_OP_MOVPW && i_instr[7:4] > 4'h1 |=>
    o_gpr_we && o_gpr_data[31:0] == 32'h0000_0000) else $error("reserved read not zero");
  flag_sticky_a: assert property (!$fell(o_float_inexact_flag))
    else $error("sticky flag dropped");
endmodule // mmn_exec_chk

bind mmn_exec mmn_exec_chk #(.W(W)) u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_valid(i_valid),
  .i_op(i_op), .i_instr(i_instr), .i_user_mode(i_user_mode), .i_fpr_a(i_fpr_a), .i_fmul_exc(i_fmul_exc),
  .i_fexc_en(i_fexc_en), .o_done(o_done), .o_gpr_we(o_gpr_we), .o_gpr_we_hi(o_gpr_we_hi),
  .o_gpr_data(o_gpr_data), .o_fpr_we(o_fpr_we), .o_fpr_data(o_fpr_data), .o_cc_we(o_cc_we),
  .o_psw(o_psw), .o_ssw(o_ssw), .o_trap_priv(o_trap_priv), .o_trap_fp(o_trap_fp),
  .o_float_inexact_flag(o_float_inexact_flag));

// ===== mmn_fmul_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Stand-in floating multiplier on the far side of the datapath.
// ****************************************************************
// It answers within the same cycle, as the real unit does towards the
// execute stage. The product is a raw pattern rather than real
// arithmetic, so expected values stay exact and cheap to compute.
module mmn_fmul_model (
  input  wire logic [63:0] i_a,       // Source float operand.
  input  wire logic [3:0]  i_exc_req, // Exceptions the bench asks for.
  input  wire logic [63:0] i_b,       // Destination float operand.
  output logic      [63:0] o_res,     // Product pattern.
  output logic      [3:0]  o_exc      // Exception flags, invalid first.
);
  // Combinational answer; exceptions only when the bench commands them.
  always_comb begin
    o_res = i_a ^ i_b;
    o_exc = i_exc_req;
  end
endmodule // mmn_fmul_model

// ===== mmn_pkg.sv
// ****************************************************************
// Shared constants for the move, multiply and negate datapath.
// ****************************************************************
package mmn_pkg;

  // Operation codes presented by the decoder on i_op.
  typedef enum logic [4:0] {
    MMN_OP_NONE,
    MMN_OP_MOVW,
    MMN_OP_MOVS,
    MMN_OP_MOVD,
    MMN_OP_MOVDL,
    MMN_OP_MOVLD,
    MMN_OP_MOVSW,
    MMN_OP_MOVWS,
    MMN_OP_MOVPW,
    MMN_OP_MOVWP,
    MMN_OP_MOVSU,
    MMN_OP_MOVUS,
    MMN_OP_MULW,
    MMN_OP_MULWU,
    MMN_OP_MULWX,
    MMN_OP_MULWUX,
    MMN_OP_MULS,
    MMN_OP_MULD,
    MMN_OP_NEGS,
    MMN_OP_NEGD,
    MMN_OP_LOADFS
  } mmn_op_t;

  // Opcode byte values in bits 15 to 8 of the register format.
  localparam logic [7:0]  MMN_OPC_MULD     = 8'h2A;
  localparam logic [7:0]  MMN_OPC_MULS     = 8'h28;
  localparam logic [7:0]  MMN_OPC_MULW     = 8'h98;
  // Field positions of the register format.
  localparam int          MMN_OPC_HI       = 15;
  localparam int          MMN_OPC_LO       = 8;
  localparam int          MMN_SRC_HI       = 7;
  localparam int          MMN_SRC_LO       = 4;
  localparam int          MMN_DST_HI       = 3;
  localparam int          MMN_DST_LO       = 0;
  // Processor register selectors.
  localparam logic [3:0]  MMN_PSEL_PSW     = 4'h0;
  localparam logic [3:0]  MMN_PSEL_SSW     = 4'h1;
  // Condition code positions in the program status word.
  localparam int          MMN_CC_N         = 3;
  localparam int          MMN_CC_Z         = 2;
  localparam int          MMN_CC_V         = 1;
  localparam int          MMN_CC_C         = 0;
  // Reset values of the held status words.
  localparam logic [31:0] MMN_PSW_RST      = 32'h0000_0000;
  localparam logic [31:0] MMN_SSW_RST      = 32'h0000_0000;
  // Sign bit positions of single and double floats.
  localparam int          MMN_SGN_S        = 31;
  localparam int          MMN_SGN_D        = 63;

endpackage : mmn_pkg

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Signals, notes and the design under test.
  // ****************************************************************
  // A note: strobes {gpr, fpr, priv trap, fp trap}, masked values, then the operation and its word.
  typedef struct {logic [3:0] st; logic [63:0] g, gm, f, fm; logic [31:0] p, pm;
                  mmn_pkg::mmn_op_t op; logic [15:0] ins;} mmn_note_t;
  localparam logic [63:0] LO = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] AL = 64'hFFFF_FFFF_FFFF_FFFF;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_valid = 1'b0, i_user_mode = 1'b0;
  mmn_pkg::mmn_op_t i_op = mmn_pkg::MMN_OP_NONE;
  logic [15:0] i_instr = 16'h0000;
  logic [31:0] i_pc = '0, i_gpr_a = '0, i_gpr_b = '0, o_psw, o_ssw, a, b, pc, psv;
  logic [63:0] i_fpr_a = '0, i_fpr_b = '0, i_fmul_res, o_gpr_data, o_fpr_data, fa, fb, ps, pu;
  logic [3:0]  i_fmul_exc, i_fexc_en = '0, ex_req = '0, o_gpr_dst, o_fpr_dst, en, ex;
  logic o_done, o_gpr_we, o_gpr_we_hi, o_gpr_usr, o_fpr_we, o_fpr_dbl, o_cc_we, o_trap_priv, o_trap_fp;
  logic o_float_inexact_flag, o_float_underflow_flag, o_float_overflow_flag, o_float_invalid_flag;
  logic usr, ov;
  int fails = 0, tests_run = 0;
  mmn_note_t q[$], mn;

  mmn_exec #(.W(32)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op),
    .i_instr(i_instr), .i_pc(i_pc), .i_user_mode(i_user_mode), .i_gpr_a(i_gpr_a), .i_gpr_b(i_gpr_b),
    .i_fpr_a(i_fpr_a), .i_fpr_b(i_fpr_b), .i_fmul_res(i_fmul_res), .i_fmul_exc(i_fmul_exc),
    .i_fexc_en(i_fexc_en), .o_done(o_done), .o_gpr_we(o_gpr_we), .o_gpr_we_hi(o_gpr_we_hi),
    .o_gpr_usr(o_gpr_usr), .o_gpr_dst(o_gpr_dst), .o_gpr_data(o_gpr_data), .o_fpr_we(o_fpr_we),
    .o_fpr_dbl(o_fpr_dbl), .o_fpr_dst(o_fpr_dst), .o_fpr_data(o_fpr_data), .o_cc_we(o_cc_we),
    .o_trap_priv(o_trap_priv), .o_trap_fp(o_trap_fp), .o_psw(o_psw), .o_ssw(o_ssw),
    .o_float_inexact_flag(o_float_inexact_flag), .o_float_underflow_flag(o_float_underflow_flag),
    .o_float_overflow_flag(o_float_overflow_flag), .o_float_invalid_flag(o_float_invalid_flag));
  mmn_fmul_model fpu (.i_a(i_fpr_a), .i_b(i_fpr_b), .i_exc_req(ex_req), .o_res(i_fmul_res), .o_exc(i_fmul_exc));

  // Free-running 100 MHz clock.
  always #5 i_ref_clk = ~i_ref_clk;

  // ****************************************************************
  // Tasks shared by every scenario.
  // ****************************************************************
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(string what, logic [63:0] e, logic [63:0] s);
    tests_run++;
    if (e !== s) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // Presents one request at a clock edge and notes what must come back.
  task automatic issue(mmn_pkg::mmn_op_t op, logic [15:0] ins, logic [3:0] st, logic [63:0] g, gm, f, fm,
                       logic [31:0] p, pm);
    @(posedge i_ref_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_instr <= ins;
    i_gpr_a <= a;
    i_gpr_b <= b;
    i_fpr_a <= fa;
    i_fpr_b <= fb;
    i_pc <= pc;
    i_user_mode <= usr;
    i_fexc_en <= en;
    ex_req <= ex;
    q.push_back('{st, g, gm, f, fm, p, pm, op, ins});
  endtask

  // Drops the request; also keeps a register read from racing its write.
  task automatic idle();
    @(posedge i_ref_clk);
    i_valid <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Outputs are settled by the falling edge, so results are taken there.
  always @(negedge i_ref_clk) begin
    if (o_done === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected done", 64'h0, 64'h1);
      end else begin
        mn = q.pop_front();
        chk("strobes", {60'h0, mn.st}, {60'h0, o_gpr_we, o_fpr_we, o_trap_priv, o_trap_fp});
        chk("gpr data", mn.g & mn.gm, o_gpr_data & mn.gm);
        chk("fpr data", mn.f & mn.fm, o_fpr_data & mn.fm);
        chk("psw", {32'h0, mn.p & mn.pm}, {32'h0, o_psw & mn.pm});
        // A full 64-bit mask marks a pair or double write; only a supervisor bank move targets the user bank.
        chk("pair and bank", {61'h0, mn.st[3] && mn.gm == AL, mn.st[2] && mn.fm == AL,
            mn.st[3] && mn.op == mmn_pkg::MMN_OP_MOVSU}, {61'h0, o_gpr_we_hi, o_fpr_dbl, o_gpr_usr});
        chk("dests", {56'h0, (mn.op == mmn_pkg::MMN_OP_LOADFS) ? mn.ins[7:4] : mn.ins[3:0],
            mn.ins[3:0]}, {56'h0, o_gpr_dst, o_fpr_dst});
      end
    end
  end

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    fails++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    void'($urandom(32'h71b5));
    usr = 1'b0; en = '0; ex = '0; pc = '0; b = '0; fb = '0;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    // Word moves at zero, negative and random values.
    for (int j = 0; j < 3; j++) begin
      a = (j == 0) ? 32'h0 : (j == 1) ? 32'h8000_0000 : $urandom;
      issue(mmn_pkg::MMN_OP_MOVW, 16'h0031, 4'h8, {32'h0, a}, LO, '0, '0, {28'h0, a[31], a == 0, 2'b00}, 32'hE);
    end
    $display("test word move done");
    // Raw float and pair moves, then both negates, back to back.
    a = $urandom; b = $urandom; fa = {$urandom, $urandom}; fb = {$urandom, $urandom};
    issue(mmn_pkg::MMN_OP_MOVDL, 16'h0012, 4'h8, fa, AL, '0, '0, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVLD, 16'h0023, 4'h4, '0, '0, {b, a}, AL, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVSW, 16'h0012, 4'h8, fa, LO, '0, '0, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVWS, 16'h0012, 4'h4, '0, '0, {32'h0, a}, LO, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVS, 16'h0012, 4'h4, '0, '0, fa, LO, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVD, 16'h0012, 4'h4, '0, '0, fa, AL, '0, '0);
    issue(mmn_pkg::MMN_OP_NEGS, 16'h0012, 4'h4, '0, '0, fa ^ 64'h8000_0000, LO, '0, '0);
    issue(mmn_pkg::MMN_OP_NEGD, 16'h0012, 4'h4, '0, '0, fa ^ 64'h8000_0000_0000_0000, AL, '0, '0);
    $display("test raw moves done");
    // Integer multiplies: most negative times minus one, then random widths.
    for (int j = 0; j < 4; j++) begin
      a = (j == 0) ? 32'h8000_0000 : $urandom;
      b = (j == 0) ? 32'hFFFF_FFFF : $urandom >> (j * 8);
      ps = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      pu = {32'h0, a} * {32'h0, b};
      ov = ps[63:31] != {33{ps[31]}};
      issue(mmn_pkg::MMN_OP_MULW, {mmn_pkg::MMN_OPC_MULW, 8'h12}, 4'h8, ps, LO, '0, '0, {30'h0, ov, 1'b0}, 32'hF);
      issue(mmn_pkg::MMN_OP_MULWU, 16'h0012, 4'h8, pu, LO, '0, '0, {30'h0, |pu[63:32], 1'b0}, 32'hF);
      issue(mmn_pkg::MMN_OP_MULWX, 16'h0012, 4'h8, ps, AL, '0, '0, {30'h0, ov, 1'b0}, 32'hF);
      issue(mmn_pkg::MMN_OP_MULWUX, 16'h0012, 4'h8, pu, AL, '0, '0, {30'h0, |pu[63:32], 1'b0}, 32'hF);
    end
    $display("test integer multiply done");
    // Processor registers: writes, reads, a refused write and reserved places.
    a = $urandom; psv = a;
    issue(mmn_pkg::MMN_OP_MOVWP, 16'h0000, 4'h0, '0, '0, '0, '0, psv, 32'hFFFF_FFFF);
    idle();
    issue(mmn_pkg::MMN_OP_MOVPW, 16'h0003, 4'h8, {32'h0, psv}, LO, '0, '0, psv, 32'hFFFF_FFFF);
    a = $urandom; b = a;
    issue(mmn_pkg::MMN_OP_MOVWP, 16'h0011, 4'h0, '0, '0, '0, '0, psv, 32'hFFFF_FFFF);
    idle();
    usr = 1'b1; a = ~b;
    issue(mmn_pkg::MMN_OP_MOVWP, 16'h0011, 4'h0, '0, '0, '0, '0, psv, 32'hFFFF_FFFF);
    issue(mmn_pkg::MMN_OP_MOVSU, 16'h0012, 4'h2, '0, '0, '0, '0, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVUS, 16'h0012, 4'h2, '0, '0, '0, '0, '0, '0);
    idle();
    usr = 1'b0;
    issue(mmn_pkg::MMN_OP_MOVPW, 16'h0013, 4'h8, {32'h0, b}, LO, '0, '0, '0, '0);
    issue(mmn_pkg::MMN_OP_MOVWP, 16'h0055, 4'h0, '0, '0, '0, '0, psv, 32'hFFFF_FFFF);
    issue(mmn_pkg::MMN_OP_MOVPW, 16'h0053, 4'h8, '0, LO, '0, '0, '0, '0);
    a = 32'h8000_0000;
    issue(mmn_pkg::MMN_OP_MOVSU, 16'h0012, 4'h8, {32'h0, a}, LO, '0, '0, 32'h8, 32'hD);
    a = 32'h0;
    issue(mmn_pkg::MMN_OP_MOVUS, 16'h0012, 4'h8, '0, LO, '0, '0, 32'h4, 32'hE);
    $display("test processor registers done");
    // Float multiply: enabled trap, status retrieval, then an untrapped flag.
    fa = {$urandom, $urandom}; fb = {$urandom, $urandom}; pc = $urandom; en = 4'h1; ex = 4'h1;
    issue(mmn_pkg::MMN_OP_MULD, {mmn_pkg::MMN_OPC_MULD, 8'h12}, 4'h1, '0, '0, '0, '0, '0, '0);
    issue(mmn_pkg::MMN_OP_LOADFS, 16'h0052, 4'hC, {32'h0, pc}, LO, fb, AL, '0, '0);
    en = 4'h0; ex = 4'h8;
    issue(mmn_pkg::MMN_OP_MULS, {mmn_pkg::MMN_OPC_MULS, 8'h12}, 4'h4, '0, '0, fa ^ fb, LO, '0, '0);
    ex = 4'h0;
    issue(mmn_pkg::MMN_OP_MULD, {mmn_pkg::MMN_OPC_MULD, 8'h12}, 4'h4, '0, '0, fa ^ fb, AL, '0, '0);
    idle();
    @(negedge i_ref_clk);
    chk("float flags", 64'h9, {60'h0, o_float_invalid_flag, o_float_overflow_flag,
        o_float_underflow_flag, o_float_inexact_flag});
    $display("test float multiply done");
    repeat (3) @(posedge i_ref_clk);
    finish_test();
  end
endmodule // tb_top
